/* src/pcsx_defs.svh */
`ifndef PCSX_DEFS_SVH
`define PCSX_DEFS_SVH

// Register offsets on the plain register port.
`define PCSX_ADDR_W         8
`define PCSX_OFF_TEST_CTL   8'h19
`define PCSX_OFF_MISMATCH   8'h1A

// Reset values.
`define PCSX_TEST_CTL_RST   3'h0
`define PCSX_CNT_RST        32'h0000_0000

// Field positions of the test control register.
`define PCSX_BIT_TX_PAT     0
`define PCSX_BIT_RX_CHK     1
`define PCSX_BIT_CNT_CLR    2

// Control byte codes on the wide media-independent interface.
`define PCSX_CODE_IDLE      8'h07
`define PCSX_CODE_START     8'hFB
`define PCSX_CODE_TERM      8'hFD
`define PCSX_CODE_ERR       8'hFE

// Block types and sync headers of the 66-bit blocks.
`define PCSX_BT_IDLE        8'h1E
`define PCSX_BT_START       8'h78
`define PCSX_BT_TERM0       8'h87
`define PCSX_HDR_DATA       2'h1
`define PCSX_HDR_CTRL       2'h2

// Alignment marker spacing in cycles and scrambler taps.
`define PCSX_AM_INTERVAL    16384
`define PCSX_SCR_TAP_A      38
`define PCSX_SCR_TAP_B      57

`endif

/* src/pcsx_pkg.sv */
package pcsx_pkg;

    typedef enum logic [1:0] {
        TXM_NORMAL  = 2'b00,
        TXM_PATTERN = 2'b01
    } pcsx_txm_e;

    typedef struct packed {
        logic cnt_clr;
        logic rx_chk;
        logic tx_pat;
    } pcsx_tctl_s;

    typedef logic [31:0] pcsx_word_t;

endpackage : pcsx_pkg

/* src/pcsx_tx_pattern.sv */
`timescale 1ns/10ps
`include "pcsx_defs.svh"

// Scrambled idle source: idle control blocks through a scrambler that advances only on step.
module pcsx_tx_pattern import pcsx_pkg::*; #(
    parameter int WORDS = 5
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 step,
    output logic      [WORDS*64-1:0]  pat
);

    logic [57:0]         scr;
    logic [57:0]         next_scr;
    logic [WORDS*64-1:0] next_pat;

    always_comb begin
        logic [63:0] blk;
        logic        fb;
        blk      = {{56{1'b0}}, `PCSX_BT_IDLE};
        fb       = 1'b0;
        next_scr = scr;
        next_pat = '0;
        for (int w = 0; w < WORDS; w++) begin
            for (int b = 0; b < 64; b++) begin
                fb = blk[b] ^ next_scr[`PCSX_SCR_TAP_A] ^ next_scr[`PCSX_SCR_TAP_B];
                next_pat[w*64+b] = fb;
                next_scr = {next_scr[56:0], fb};
            end
        end
    end

    // The state starts from a constant; no seeding is needed.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scr <= '0;
            pat <= '0;
        end else if (step) begin
            scr <= next_scr;
            pat <= next_pat;
        end
    end

endmodule : pcsx_tx_pattern

/* src/pcsx_rx_checker.sv */
`timescale 1ns/10ps
`include "pcsx_defs.svh"

// Counts received blocks that are not scrambled-idle blocks after descrambling.
module pcsx_rx_checker import pcsx_pkg::*; #(
    parameter int WORDS = 5
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 check,
    input  wire logic                 clr,
    input  wire logic [WORDS*2-1:0]   hdr,
    input  wire logic [WORDS*64-1:0]  d,
    output logic      [7:0]           miss,
    output pcsx_word_t                count
);

    logic [32:0] sum;
    pcsx_word_t  next_count;

    always_comb begin
        miss = 8'h00;
        for (int w = 0; w < WORDS; w++) begin
            if (hdr[w*2+:2] != `PCSX_HDR_CTRL ||
                d[w*64+:64] != {{56{1'b0}}, `PCSX_BT_IDLE}) begin
                miss = miss + 8'h01;
            end
        end
        sum        = {1'b0, count} + {{25{1'b0}}, miss};
        next_count = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= `PCSX_CNT_RST;
        end else if (clr) begin
            count <= `PCSX_CNT_RST;
        end else if (check) begin
            count <= next_count;
        end
    end

endmodule : pcsx_rx_checker

/* src/pcsx_top.sv */
`timescale 1ns/10ps
`include "pcsx_defs.svh"

// Contract
// - MII is 320 or 128 bits wide
// - Control bit 0 carries any data byte
// - Control 07 idle, fb start, fd end
// - Control fe marks corrupted or invalid blocks
// - Data w*64, control w*8, LSB first
// - Ready high when transmit bus accepts data
// - Transmit lanes stable status output to user
// - Receive words LSB and low word first
// - Receive valid exactly with valid blocks; code also needs alignment, and no RX_BER_HIGH while test bit 1 is clear
// - Lanes deskewed status output driven
// - Test bit 0 sends scrambled idle pattern
// - Pattern unseeded, input is idle block 1E
// - Pattern keeps sync headers and alignment markers
// - Checker uses lock, deskew, descrambling as normal
// - Error rate monitor off in receive test
// - Idle header and payload count as match
// - Each mismatched block adds one error
// - Test bit 1 enables receive checking
// - Counter at 1A, 32 bits, saturates
// - Test bit 2 clears the counter
// - Align only when deskewed; then blocks flow
module pcsx_top import pcsx_pkg::*; #(
    parameter int WORDS       = 5,
    parameter int AM_INTERVAL = `PCSX_AM_INTERVAL
) (
    input  wire logic                      CORE_CLK,
    input  wire logic                      RSTN,
    input  wire logic [`PCSX_ADDR_W-1:0]   REG_ADDR,
    input  wire logic [31:0]               REG_WDATA,
    input  wire logic                      REG_WR,
    input  wire logic                      REG_RD,
    output pcsx_word_t                     REG_RDATA,
    input  wire logic [WORDS*64-1:0]       TX_MII_D,
    input  wire logic [WORDS*8-1:0]        TX_MII_C,
    input  wire logic                      TX_MII_VALID,
    output logic                           TX_MII_READY,
    input  wire logic                      TX_LANE_LOCK,
    output logic                           TX_LANES_STABLE,
    input  wire logic                      TX_PCS_READY,
    output logic      [WORDS*64-1:0]       TX_PCS_D,
    output logic      [WORDS*8-1:0]        TX_PCS_C,
    output logic      [WORDS*2-1:0]        TX_PCS_HDR,
    output logic                           TX_PCS_VALID,
    output logic                           TX_PCS_AM,
    input  wire logic [WORDS*2-1:0]        RX_BLK_HDR,
    input  wire logic [WORDS*64-1:0]       RX_BLK_D,
    input  wire logic                      RX_BLK_VALID,
    input  wire logic                      RX_BLOCK_LOCK,
    input  wire logic                      RX_AM_LOCK,
    input  wire logic                      RX_DESKEW_DONE,
    input  wire logic                      RX_BER_HIGH,
    output logic      [WORDS*64-1:0]       RX_MII_D,
    output logic      [WORDS*8-1:0]        RX_MII_C,
    output logic                           RX_MII_VALID,
    output logic                           LANES_DESKEWED,
    output logic                           ALIGN_STATUS,
    output logic                           EXCESS_ERROR_RATE,
    output logic                           BER_MON_EN
);

    localparam int DW = WORDS * 64;
    localparam int CW = WORDS * 8;
    localparam int HW = WORDS * 2;

    logic          rst_meta;
    logic          rst_n;
    pcsx_tctl_s    tctl;
    pcsx_txm_e     txm;
    pcsx_txm_e     next_txm;
    logic          tx_take;
    logic          pat_step;
    logic [DW-1:0] pat;
    logic [31:0]   am_cnt;
    logic          align;
    logic          ber_gated;
    logic          rx_ok;
    logic          chk_en;
    logic [DW-1:0] dec_d;
    logic [CW-1:0] dec_c;
    logic [7:0]    mis_n;
    pcsx_word_t    mis_count;

    // Reset release through two flip-flops.
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Test control register writes.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tctl <= `PCSX_TEST_CTL_RST;
        end else if (REG_WR && REG_ADDR == `PCSX_OFF_TEST_CTL) begin
            tctl.tx_pat  <= REG_WDATA[`PCSX_BIT_TX_PAT];
            tctl.rx_chk  <= REG_WDATA[`PCSX_BIT_RX_CHK];
            tctl.cnt_clr <= REG_WDATA[`PCSX_BIT_CNT_CLR];
        end
    end

    // Register reads; data stand only in the cycle after the strobe.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_RD) begin
            if (REG_ADDR == `PCSX_OFF_TEST_CTL) begin
                REG_RDATA <= 32'h0000_0000;
                REG_RDATA[`PCSX_BIT_TX_PAT]  <= tctl.tx_pat;
                REG_RDATA[`PCSX_BIT_RX_CHK]  <= tctl.rx_chk;
                REG_RDATA[`PCSX_BIT_CNT_CLR] <= tctl.cnt_clr;
            end else if (REG_ADDR == `PCSX_OFF_MISMATCH) begin
                REG_RDATA <= mis_count;
            end else begin
                REG_RDATA <= 32'h0000_0000;
            end
        end else begin
            REG_RDATA <= 32'h0000_0000;
        end
    end

    // Transmit source selection.
    always_comb begin
        case (txm)
            TXM_NORMAL:  next_txm = tctl.tx_pat ? TXM_PATTERN : TXM_NORMAL;
            TXM_PATTERN: next_txm = tctl.tx_pat ? TXM_PATTERN : TXM_NORMAL;
            default:     next_txm = TXM_NORMAL;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            txm <= TXM_NORMAL;
        end else begin
            txm <= next_txm;
        end
    end

    function automatic logic [HW-1:0] tx_hdr(input logic [CW-1:0] c);
        logic [HW-1:0] h;
        h = '0;
        for (int w = 0; w < WORDS; w++) begin
            h[w*2+:2] = (|c[w*8+:8]) ? `PCSX_HDR_CTRL : `PCSX_HDR_DATA;
        end
        return h;
    endfunction : tx_hdr

    assign tx_take  = TX_MII_VALID && TX_MII_READY;
    assign pat_step = (txm == TXM_PATTERN) && TX_PCS_READY;

    // Ready follows the encoder slot, stable lanes and normal mode.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            TX_MII_READY    <= 1'b0;
            TX_LANES_STABLE <= 1'b0;
        end else begin
            TX_MII_READY    <= TX_PCS_READY && TX_LANE_LOCK && !tctl.tx_pat;
            TX_LANES_STABLE <= TX_LANE_LOCK;
        end
    end

    pcsx_tx_pattern #(
        .WORDS (WORDS)
    ) u_pattern (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .step  (pat_step),
        .pat   (pat)
    );

    // Transmit block register toward the encoder.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            TX_PCS_VALID <= 1'b0;
            TX_PCS_D     <= '0;
            TX_PCS_C     <= '0;
            TX_PCS_HDR   <= '0;
        end else begin
            TX_PCS_VALID <= tx_take || pat_step;
            if (pat_step) begin
                TX_PCS_D   <= pat;
                TX_PCS_C   <= {CW{1'b1}};
                TX_PCS_HDR <= {WORDS{`PCSX_HDR_CTRL}};
            end else if (tx_take) begin
                TX_PCS_D   <= TX_MII_D;
                TX_PCS_C   <= TX_MII_C;
                TX_PCS_HDR <= tx_hdr(TX_MII_C);
            end
        end
    end

    // Alignment marker slots recur in both modes.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            am_cnt    <= 32'h0000_0000;
            TX_PCS_AM <= 1'b0;
        end else begin
            TX_PCS_AM <= (am_cnt == 32'(AM_INTERVAL - 1));
            am_cnt    <= (am_cnt == 32'(AM_INTERVAL - 1)) ? 32'h0000_0000
                                                          : am_cnt + 32'h0000_0001;
        end
    end

    // Receive side.
    function automatic logic [71:0] decode_word(input logic [1:0]  hdr,
                                                input logic [63:0] d);
        logic [71:0] r;
        r = {8'hFF, {8{`PCSX_CODE_ERR}}};
        if (hdr == `PCSX_HDR_DATA) begin
            r = {8'h00, d};
        end else if (hdr == `PCSX_HDR_CTRL) begin
            if (d[7:0] == `PCSX_BT_IDLE) begin
                r = {8'hFF, {8{`PCSX_CODE_IDLE}}};
            end else if (d[7:0] == `PCSX_BT_START) begin
                r = {8'h01, d[63:8], `PCSX_CODE_START};
            end else if (d[7:0] == `PCSX_BT_TERM0) begin
                r = {8'hFF, {7{`PCSX_CODE_IDLE}}, `PCSX_CODE_TERM};
            end
        end
        return r;
    endfunction : decode_word

    assign align     = RX_BLOCK_LOCK && RX_AM_LOCK && RX_DESKEW_DONE;
    assign ber_gated = RX_BER_HIGH && !tctl.rx_chk;
    assign rx_ok     = RX_BLK_VALID && align && !ber_gated;
    assign chk_en    = RX_BLK_VALID && align && tctl.rx_chk;

    always_comb begin
        dec_d = '0;
        dec_c = '0;
        for (int w = 0; w < WORDS; w++) begin
            {dec_c[w*8+:8], dec_d[w*64+:64]} = decode_word(RX_BLK_HDR[w*2+:2],
                                                           RX_BLK_D[w*64+:64]);
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            RX_MII_VALID <= 1'b0;
            RX_MII_D     <= '0;
            RX_MII_C     <= '0;
        end else begin
            RX_MII_VALID <= rx_ok;
            if (rx_ok) begin
                RX_MII_D <= dec_d;
                RX_MII_C <= dec_c;
            end
        end
    end

    // Status outputs.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            LANES_DESKEWED    <= 1'b0;
            ALIGN_STATUS      <= 1'b0;
            EXCESS_ERROR_RATE <= 1'b0;
            BER_MON_EN        <= 1'b0;
        end else begin
            LANES_DESKEWED    <= RX_DESKEW_DONE;
            ALIGN_STATUS      <= align;
            EXCESS_ERROR_RATE <= ber_gated;
            BER_MON_EN        <= !tctl.rx_chk;
        end
    end

    pcsx_rx_checker #(
        .WORDS (WORDS)
    ) u_checker (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .check (chk_en),
        .clr   (tctl.cnt_clr),
        .hdr   (RX_BLK_HDR),
        .d     (RX_BLK_D),
        .miss  (mis_n),
        .count (mis_count)
    );

    // Checks and scenario coverage.
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!rst_n);

    a_ready_cause: assert property (
        TX_MII_READY |-> $past(TX_PCS_READY && TX_LANE_LOCK && !tctl.tx_pat))
        else $error("transmit ready without a free slot");

    a_tx_transfer: assert property (
        tx_take |=> TX_PCS_VALID && TX_PCS_D == $past(TX_MII_D)
                    && TX_PCS_C == $past(TX_MII_C))
        else $error("accepted transmit block not forwarded");

    a_pattern_only: assert property (
        txm == TXM_PATTERN |-> !TX_MII_READY)
        else $error("traffic accepted during pattern mode");

    a_pattern_hdr: assert property (
        pat_step |=> TX_PCS_VALID && TX_PCS_HDR == {WORDS{`PCSX_HDR_CTRL}})
        else $error("pattern block without control headers");

    a_rx_valid: assert property (
        1'b1 |=> RX_MII_VALID == $past(rx_ok))
        else $error("receive valid does not follow valid blocks");

    a_idle_map: assert property (
        rx_ok && RX_BLK_HDR[1:0] == `PCSX_HDR_CTRL && RX_BLK_D[7:0] == `PCSX_BT_IDLE
        |=> RX_MII_C[7:0] == 8'hFF && RX_MII_D[7:0] == `PCSX_CODE_IDLE)
        else $error("idle block not decoded to idle");

    a_error_map: assert property (
        rx_ok && RX_BLK_HDR[1:0] == 2'h0
        |=> RX_MII_C[0] && RX_MII_D[7:0] == `PCSX_CODE_ERR)
        else $error("bad header not decoded to error");

    a_data_map: assert property (
        rx_ok && RX_BLK_HDR[1:0] == `PCSX_HDR_DATA
        |=> RX_MII_C[7:0] == 8'h00 && RX_MII_D[63:0] == $past(RX_BLK_D[63:0]))
        else $error("data block altered");

    a_ber_off: assert property (
        tctl.rx_chk |=> !EXCESS_ERROR_RATE && !BER_MON_EN)
        else $error("error rate monitor active in receive test");

    a_cnt_clear: assert property (
        tctl.cnt_clr |=> mis_count == 32'h0000_0000)
        else $error("counter not held at zero");

    a_cnt_sat: assert property (
        mis_count == 32'hFFFF_FFFF && !tctl.cnt_clr |=> mis_count == 32'hFFFF_FFFF)
        else $error("counter wrapped");

    a_cnt_step: assert property (
        chk_en && !tctl.cnt_clr && mis_count < 32'hFFFF_FF00
        |=> mis_count == $past(mis_count) + {24'h00_0000, $past(mis_n)})
        else $error("mismatch count wrong");

    a_rd_count: assert property (
        REG_RD && REG_ADDR == `PCSX_OFF_MISMATCH |=> REG_RDATA == $past(mis_count))
        else $error("counter read returns wrong value");

    a_deskew_out: assert property (
        1'b1 |=> LANES_DESKEWED == $past(RX_DESKEW_DONE))
        else $error("deskew status not forwarded");

    c_tx_take:  cover property (tx_take ##1 tx_take);
    c_pattern:  cover property (pat_step ##1 TX_PCS_AM);
    c_mismatch: cover property (chk_en && mis_n != 8'h00);
    c_clear:    cover property (mis_count != 32'h0000_0000 ##1 tctl.cnt_clr);

endmodule : pcsx_top

/* test/pcsx_mac_model.sv */
`timescale 1ns/10ps

// Client side of the transmit interface: sends queued blocks and holds each until taken.
module pcsx_mac_model import pcsx_pkg::*; #(
    parameter int WORDS = 5
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 ready,
    output logic      [WORDS*64-1:0]  d,
    output logic      [WORDS*8-1:0]   c,
    output logic                      valid
);
    logic [WORDS*72-1:0] q[$];

    task automatic push(input logic [WORDS*64-1:0] bd, input logic [WORDS*8-1:0] bc);
        q.push_back({bc, bd});
    endtask : push

    // A block stays on the bus until an edge sees valid and ready together.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid <= 1'b0;
            d     <= '0;
            c     <= '0;
        end else if (!valid || ready) begin
            if (q.size() > 0) begin
                {c, d} <= q.pop_front();
                valid  <= 1'b1;
            end else begin
                valid <= 1'b0;
                d     <= ~d;
                c     <= ~c;
            end
        end
    end
endmodule : pcsx_mac_model

/* test/pcsx_top_test.sv */
`timescale 1ns/10ps
`include "pcsx_defs.svh"

module pcsx_top_test import pcsx_pkg::*;;
    localparam int W = 5;
    logic clk, rstn, wr, rd, tx_v, tx_rdy, lane_lock, lanes_stable, pcs_rdy, pcs_v, pcs_am;
    logic rx_v, blk_lock, am_lock, dsk_done, ber_hi, rxm_v, deskewed, align, excess, ber_en;
    logic [7:0]     addr;
    logic [31:0]    wdata;
    pcsx_word_t     rdata, v;
    logic [W*64-1:0] tx_d, pcs_d, rx_d, rxm_d;
    logic [W*8-1:0]  tx_c, pcs_c, rxm_c;
    logic [W*2-1:0]  pcs_hdr, rx_hdr;
    int n_fail = 0;
    int tests_run = 0;

    pcsx_top #(.WORDS(W), .AM_INTERVAL(8)) u_dut (
        .CORE_CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .TX_MII_D(tx_d), .TX_MII_C(tx_c),
        .TX_MII_VALID(tx_v), .TX_MII_READY(tx_rdy), .TX_LANE_LOCK(lane_lock),
        .TX_LANES_STABLE(lanes_stable), .TX_PCS_READY(pcs_rdy), .TX_PCS_D(pcs_d),
        .TX_PCS_C(pcs_c), .TX_PCS_HDR(pcs_hdr), .TX_PCS_VALID(pcs_v), .TX_PCS_AM(pcs_am),
        .RX_BLK_HDR(rx_hdr), .RX_BLK_D(rx_d), .RX_BLK_VALID(rx_v), .RX_BLOCK_LOCK(blk_lock),
        .RX_AM_LOCK(am_lock), .RX_DESKEW_DONE(dsk_done), .RX_BER_HIGH(ber_hi),
        .RX_MII_D(rxm_d), .RX_MII_C(rxm_c), .RX_MII_VALID(rxm_v), .LANES_DESKEWED(deskewed),
        .ALIGN_STATUS(align), .EXCESS_ERROR_RATE(excess), .BER_MON_EN(ber_en)
    );

    pcsx_mac_model #(.WORDS(W)) u_mac (
        .clk(clk), .rst_n(rstn), .ready(tx_rdy), .d(tx_d), .c(tx_c), .valid(tx_v)
    );

    always #50 clk = ~clk;

    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check

    task automatic results;
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] val);
        @(posedge clk);
        addr  <= a;
        wdata <= val;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output pcsx_word_t val);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 val = rdata;
    endtask : reg_rd

    task automatic rx_send(input logic [W*2-1:0] h, input logic [W*64-1:0] dv);
        @(posedge clk);
        rx_hdr <= h;
        rx_d   <= dv;
        rx_v   <= 1'b1;
        @(posedge clk);
        rx_v   <= 1'b0;
        rx_hdr <= ~h;
        rx_d   <= ~dv;
        #1;
    endtask : rx_send

    task automatic tx_expect(input logic [W*64-1:0] ed, input logic [W*8-1:0] ec);
        logic           got;
        logic [W*2-1:0] eh;
        got = 1'b0;
        for (int k = 0; k < W; k++) begin
            eh[2*k+:2] = (ec[8*k+:8] != 8'h00) ? 2'h2 : 2'h1;
        end
        for (int i = 0; i < 10 && !got; i++) begin
            @(posedge clk);
            #1 got = (pcs_v === 1'b1);
        end
        check(got && pcs_d === ed && pcs_c === ec && pcs_hdr === eh, "transmit block");
    endtask : tx_expect

    task automatic test_regs;
        reg_rd(`PCSX_OFF_TEST_CTL, v);
        check(v === 32'h0000_0000, "control reset value");
        reg_rd(`PCSX_OFF_MISMATCH, v);
        check(v === 32'h0000_0000, "counter reset value");
        reg_wr(`PCSX_OFF_TEST_CTL, 32'hFFFF_FFF8);
        reg_wr(8'h33, 32'hFFFF_FFFF);
        reg_wr(`PCSX_OFF_MISMATCH, 32'h1234_5678);
        reg_rd(`PCSX_OFF_TEST_CTL, v);
        check(v === 32'h0000_0000, "control upper bits");
        reg_rd(8'h33, v);
        check(v === 32'h0000_0000, "unmapped read");
        reg_rd(`PCSX_OFF_MISMATCH, v);
        check(v === 32'h0000_0000, "counter is read only");
        reg_wr(`PCSX_OFF_TEST_CTL, 32'h0000_0003);
        reg_rd(`PCSX_OFF_TEST_CTL, v);
        check(v === 32'h0000_0003, "control readback");
        reg_wr(`PCSX_OFF_TEST_CTL, 32'h0000_0000);
    endtask : test_regs

    task automatic test_tx;
        logic [W*64-1:0] bd;
        bd = {W{64'hA5A5_0F0F_1234_5678}};
        // Pattern mode ends one cycle late; let its last block pass first.
        repeat (2) @(posedge clk);
        check(lanes_stable === 1'b1, "lanes stable");
        u_mac.push(bd, '0);
        u_mac.push({W*8{8'h07}}, {W{8'hFF}});
        tx_expect(bd, '0);
        tx_expect({W*8{8'h07}}, {W{8'hFF}});
        @(posedge clk);
        pcs_rdy <= 1'b0;
        repeat (2) @(posedge clk);
        u_mac.push(~bd, {W{8'h01}});
        repeat (4) begin
            @(posedge clk);
            #1 check(pcs_v === 1'b0 && tx_rdy === 1'b0, "stall");
        end
        @(posedge clk);
        pcs_rdy <= 1'b1;
        tx_expect(~bd, {W{8'h01}});
        @(posedge clk);
        lane_lock <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check(lanes_stable === 1'b0 && tx_rdy === 1'b0, "lanes unstable");
        lane_lock <= 1'b1;
    endtask : test_tx

    task automatic test_pattern;
        int          nv, am, bad;
        logic [57:0] ds;
        logic [63:0] wd;
        nv  = 0;
        am  = 0;
        bad = 0;
        ds  = '0;
        reg_wr(`PCSX_OFF_TEST_CTL, 32'h0000_0001);
        repeat (2) @(posedge clk);
        repeat (16) begin
            @(posedge clk);
            #1;
            if (pcs_v === 1'b1) begin
                nv++;
                if (pcs_c !== {W{8'hFF}} || pcs_hdr !== {W{2'h2}}) bad++;
                for (int k = 0; k < W*64; k++) begin
                    wd[k%64] = pcs_d[k] ^ ds[38] ^ ds[57];
                    ds       = {ds[56:0], pcs_d[k]};
                    if (k % 64 == 63 && nv > 1 && wd !== 64'h0000_0000_0000_001E) bad++;
                end
            end
            if (pcs_am === 1'b1) am++;
        end
        check(nv >= 14 && bad == 0, "pattern blocks");
        check(am == 2, "marker spacing");
        check(tx_rdy === 1'b0, "client held off");
        reg_wr(`PCSX_OFF_TEST_CTL, 32'h0000_0000);
    endtask : test_pattern

    task automatic rx_case(input logic [1:0] h, input logic [63:0] w, input logic [63:0] ew,
                           input logic [7:0] ec);
        logic [W*64-1:0] dv, ed;
        for (int k = 0; k < W; k++) begin
            dv[64*k+:64] = (h == 2'h1) ? w ^ 64'(k) : w;
            ed[64*k+:64] = (h == 2'h1) ? ew ^ 64'(k) : ew;
        end
        rx_send({W{h}}, dv);
        check(rxm_v === 1'b1 && rxm_d === ed && rxm_c === {W{ec}}, "receive decode");
    endtask : rx_case

    task automatic test_rx;
        rx_case(2'h1, 64'hFEDC_BA98_7654_3210, 64'hFEDC_BA98_7654_3210, 8'h00);
        rx_case(2'h2, 64'h0000_0000_0000_001E, {8{8'h07}}, 8'hFF);
        rx_case(2'h2, 64'h1122_3344_5566_7778, 64'h1122_3344_5566_77FB, 8'h01);
        rx_case(2'h2, 64'h0000_0000_0000_0087, 64'h0707_0707_0707_07FD, 8'hFF);
        rx_case(2'h0, 64'h0000_0000_0000_0000, {8{8'hFE}}, 8'hFF);
        rx_case(2'h2, 64'h0000_0000_0000_0055, {8{8'hFE}}, 8'hFF);
        @(posedge clk);
        #1 check(rxm_v === 1'b0 && align === 1'b1 && deskewed === 1'b1, "idle");
        dsk_done <= 1'b0;
        rx_send({W{2'h1}}, '0);
        check(rxm_v === 1'b0 && align === 1'b0 && deskewed === 1'b0, "no deskew");
        dsk_done <= 1'b1;
        ber_hi   <= 1'b1;
        rx_send({W{2'h1}}, '0);
        check(rxm_v === 1'b0 && excess === 1'b1 && ber_en === 1'b1, "high error");
    endtask : test_rx

    task automatic test_checker;
        reg_wr(`PCSX_OFF_TEST_CTL, 32'h0000_0002);
        rx_send({W{2'h2}}, {W{64'h0000_0000_0000_001E}});
        check(excess === 1'b0 && ber_en === 1'b0 && rxm_v === 1'b1, "monitor off");
        rx_send({W{2'h1}}, '0);
        rx_send({{(W-1){2'h2}}, 2'h1}, {W{64'h0000_0000_0000_001E}});
        reg_rd(`PCSX_OFF_MISMATCH, v);
        check(v === 32'h0000_0006, "mismatch count");
        am_lock <= 1'b0;
        rx_send({W{2'h1}}, '0);
        am_lock <= 1'b1;
        reg_rd(`PCSX_OFF_MISMATCH, v);
        check(v === 32'h0000_0006, "no count unaligned");
        reg_wr(`PCSX_OFF_TEST_CTL, 32'h0000_0006);
        rx_send({W{2'h1}}, '0);
        reg_rd(`PCSX_OFF_MISMATCH, v);
        check(v === 32'h0000_0000, "cleared");
        reg_wr(`PCSX_OFF_TEST_CTL, 32'h0000_0002);
        rx_send({W{2'h1}}, '0);
        reg_rd(`PCSX_OFF_MISMATCH, v);
        check(v === 32'h0000_0005, "count resumes");
        reg_wr(`PCSX_OFF_TEST_CTL, 32'h0000_0000);
        ber_hi <= 1'b0;
    endtask : test_checker

    initial begin
        clk       = 1'b0;
        rstn      = 1'b0;
        {wr, rd, rx_v, ber_hi} = '0;
        {lane_lock, pcs_rdy, blk_lock, am_lock, dsk_done} = '1;
        addr      = '0;
        wdata     = '0;
        rx_hdr    = '0;
        rx_d      = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        test_regs();
        test_tx();
        test_pattern();
        test_rx();
        test_checker();
        results();
    end

    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        results();
    end
endmodule : pcsx_top_test
